// file: core/qs_pkg.sv
/*
  Shared constants for the egress queue scheduler: register map, field
  positions, reset values and the queue-split encoding.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package qs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPORT = 5;
  localparam int NQ    = 4;
  localparam int DEPTH = 4;
  localparam int IDW   = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] PORT_STRIDE = 12'h020;
  localparam logic [11:0] PORT_SPAN   = 12'h0a0;
  localparam logic [4:0]  OFF_PCTL0   = 5'h00;
  localparam logic [4:0]  OFF_PCTL9   = 5'h04;
  localparam logic [4:0]  OFF_WGT0    = 5'h08;
  localparam logic [4:0]  OFF_WGT3    = 5'h14;
  localparam logic [4:0]  OFF_SCHED   = 5'h18;
  localparam logic [4:0]  OFF_STAT    = 5'h1c;
  localparam logic [11:0] ADDR_TAGMAP = 12'h100;
  localparam logic [11:0] ADDR_QMAP   = 12'h104;
  localparam logic [11:0] ADDR_DSCP0  = 12'h110;
  localparam logic [11:0] ADDR_DSCP3  = 12'h11c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC0_SPLIT_LO = 0;
  localparam int PC0_PRIO_LSB = 3;
  localparam int PC0_TAG_EN   = 5;
  localparam int PC0_DSCP_EN  = 6;
  localparam int PC9_SPLIT_HI = 1;
  localparam int QMAP_LSB     = 6;
  localparam int SCHED_WFQ    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]   PCTL0_RST  = 8'h00;
  localparam logic [7:0]   PCTL9_RST  = 8'h00;
  localparam logic [6:0]   WGT0_RST   = 7'h01;
  localparam logic [6:0]   WGT1_RST   = 7'h02;
  localparam logic [6:0]   WGT2_RST   = 7'h04;
  localparam logic [6:0]   WGT3_RST   = 7'h08;
  localparam logic [15:0]  TAGMAP_RST = 16'hfa50;
  localparam logic [1:0]   QMAP_RST   = 2'h2;
  localparam logic [127:0] DSCP_RST   = 128'h0;

  // ----------------------------------------------------------------
  // Queue split selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPLIT_ONE  = 2'b00,
    SPLIT_TWO  = 2'b01,
    SPLIT_FOUR = 2'b10
  } qs_split_e;

endpackage

// file: core/qs_sched.sv
/*
  One egress port's queue selector: strict priority or weighted fair
  queuing over four queues.
  Assumes take is pulsed only while pick_valid is high.
*/
module qs_sched
  import qs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] nonempty,
  input  wire logic       wfq_mode,
  input  wire logic [6:0] wgt0,
  input  wire logic [6:0] wgt1,
  input  wire logic [6:0] wgt2,
  input  wire logic [6:0] wgt3,
  input  wire logic       take,
  output logic            pick_valid,
  output logic [1:0]      pick
);
  import qs_pkg::*;

  function automatic logic [1:0] qs_top(input logic [3:0] m);
    qs_top = m[3] ? 2'd3 : m[2] ? 2'd2 : m[1] ? 2'd1 : 2'd0;
  endfunction

  logic [6:0] credit_r [0:3];
  logic [3:0] has_credit;
  logic [3:0] eligible;
  logic       reload;
  logic [6:0] wgt [0:3];

  assign wgt[0] = wgt0;
  assign wgt[1] = wgt1;
  assign wgt[2] = wgt2;
  assign wgt[3] = wgt3;

  for (genvar i = 0; i < 4; i++) begin : g_cr
    assign has_credit[i] = (credit_r[i] != 7'h00);
  end

  assign eligible   = nonempty & has_credit;
  assign reload     = wfq_mode && (eligible == 4'h0);
  assign pick_valid = (nonempty != 4'h0);
  // Queue 3 wins ties: highest priority first
  assign pick = (wfq_mode && !reload) ? qs_top(eligible) : qs_top(nonempty);

  // ----------------------------------------------------------------
  // Credits: refilled from the weights once every backlogged queue is spent
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_r[0] <= WGT0_RST;
      credit_r[1] <= WGT1_RST;
      credit_r[2] <= WGT2_RST;
      credit_r[3] <= WGT3_RST;
    end else if (take && wfq_mode) begin
      for (int i = 0; i < 4; i++) begin
        if (reload) begin
          credit_r[i] <= (pick == 2'(i) && wgt[i] != 7'h00) ? wgt[i] - 7'h01 : wgt[i];
        end else if (pick == 2'(i)) begin
          credit_r[i] <= credit_r[i] - 7'h01;
        end
      end
    end
  end

endmodule

// file: core/qs_egress_queue_scheduler.sv
/*
  Five-port QoS classifier and egress queue scheduler with APB registers.
  Frames are handled as descriptors (an id); the fabric offers one per
  cycle and each egress MAC pulses eg_done when a frame has left.
*/
// The APB slave port and the placing of the registers were decided locally.
module qs_egress_queue_scheduler
  import qs_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    in_valid,
  output logic                         in_ready,
  input  wire logic [2:0]              in_src_port,
  input  wire logic [2:0]              in_dst_port,
  input  wire logic [qs_pkg::IDW-1:0]  in_frame_id,
  input  wire logic                    in_tagged,
  input  wire logic [2:0]              in_tag_prio,
  input  wire logic                    in_ip,
  input  wire logic [7:0]              in_tos,
  output logic [4:0]                   eg_valid,
  output logic [5*qs_pkg::IDW-1:0]     eg_frame_id,
  output logic [9:0]                   eg_queue,
  input  wire logic [4:0]              eg_done
);
  import qs_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] qs_queue_of(input logic [1:0] split, input logic [1:0] prio,
                                             input logic [1:0] qmap);
    case (split)
      SPLIT_FOUR: qs_queue_of = prio;
      SPLIT_TWO:  qs_queue_of = (prio >= qmap) ? 2'd1 : 2'd0;
      default:    qs_queue_of = 2'd0;
    endcase
  endfunction

  function automatic logic [4:0] qs_slot(input logic [2:0] port, input logic [1:0] q);
    qs_slot = 5'(port) * 5'd4 + 5'(q);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]   pctl0_r  [0:NPORT-1];
  logic [7:0]   pctl9_r  [0:NPORT-1];
  logic [6:0]   wgt_r    [0:NPORT-1][0:NQ-1];
  logic         wfq_r    [0:NPORT-1];
  logic [15:0]  tagmap_r;
  logic [1:0]   two_queue_priority_map_r;
  logic [127:0] dscp_r;
  logic [31:0]  prdata_r;

  // ----------------------------------------------------------------
  // Queue storage and egress state
  // ----------------------------------------------------------------
  logic [IDW-1:0] mem_r    [0:NPORT*NQ-1][0:DEPTH-1];
  logic [1:0]     wr_ptr_r [0:NPORT*NQ-1];
  logic [1:0]     rd_ptr_r [0:NPORT*NQ-1];
  logic [2:0]     cnt_r    [0:NPORT*NQ-1];
  logic [4:0]     busy_r;
  logic [IDW-1:0] eg_id_r  [0:NPORT-1];
  logic [1:0]     eg_q_r   [0:NPORT-1];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic        in_ports;
  logic [2:0]  a_port;
  logic [4:0]  a_off;
  logic        a_pctl0;
  logic        a_pctl9;
  logic        a_wgt;
  logic [1:0]  a_wq;
  logic        a_sched;
  logic        a_stat;
  logic        a_tagmap;
  logic        a_qmap;
  logic        a_dscp;
  logic [1:0]  a_dw;
  logic        a_hit;
  logic        wr_en;
  logic [31:0] rdata;

  assign in_ports = (paddr < PORT_SPAN) && (paddr[1:0] == 2'b00);
  assign a_port   = 3'(paddr[11:5]);
  assign a_off    = paddr[4:0];
  assign a_pctl0  = in_ports && a_off == OFF_PCTL0;
  assign a_pctl9  = in_ports && a_off == OFF_PCTL9;
  assign a_wgt    = in_ports && a_off >= OFF_WGT0 && a_off <= OFF_WGT3;
  assign a_wq     = 2'((a_off - OFF_WGT0) >> 2);
  assign a_sched  = in_ports && a_off == OFF_SCHED;
  assign a_stat   = in_ports && a_off == OFF_STAT;
  assign a_tagmap = paddr == ADDR_TAGMAP;
  assign a_qmap   = paddr == ADDR_QMAP;
  assign a_dscp   = paddr >= ADDR_DSCP0 && paddr <= ADDR_DSCP3 && paddr[1:0] == 2'b00;
  assign a_dw     = paddr[3:2];
  assign a_hit    = a_pctl0 | a_pctl9 | a_wgt | a_sched | a_stat | a_tagmap | a_qmap | a_dscp;
  // Zero wait states; writes land at the access edge
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !a_hit;
  assign wr_en    = psel && penable && pwrite && a_hit;
  assign prdata   = prdata_r;

  logic [2:0] rp;
  assign rp = in_ports ? a_port : 3'd0;

  logic [31:0] stat_word;
  logic [3:0]  nonempty [0:NPORT-1];
  assign stat_word = {21'h0, eg_q_r[rp], busy_r[rp], 4'h0, nonempty[rp]};

  always_comb begin
    rdata = 32'h0;
    if (a_pctl0) begin
      rdata = {24'h0, pctl0_r[rp]};
    end else if (a_pctl9) begin
      rdata = {24'h0, pctl9_r[rp]};
    end else if (a_wgt) begin
      rdata = {25'h0, wgt_r[rp][a_wq]};
    end else if (a_sched) begin
      rdata = {31'h0, wfq_r[rp]};
    end else if (a_stat) begin
      rdata = stat_word;
    end else if (a_tagmap) begin
      rdata = {16'h0, tagmap_r};
    end else if (a_qmap) begin
      rdata = {24'h0, two_queue_priority_map_r, 6'h00};
    end else if (a_dscp) begin
      rdata = dscp_r[32*a_dw +: 32];
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORT; p++) begin
        pctl0_r[p]  <= PCTL0_RST;
        pctl9_r[p]  <= PCTL9_RST;
        wfq_r[p]    <= 1'b0;
        wgt_r[p][0] <= WGT0_RST;
        wgt_r[p][1] <= WGT1_RST;
        wgt_r[p][2] <= WGT2_RST;
        wgt_r[p][3] <= WGT3_RST;
      end
      tagmap_r                 <= TAGMAP_RST;
      two_queue_priority_map_r <= QMAP_RST;
      dscp_r                   <= DSCP_RST;
    end else if (wr_en) begin
      if (a_pctl0) pctl0_r[a_port] <= pwdata[7:0];
      if (a_pctl9) pctl9_r[a_port] <= pwdata[7:0];
      if (a_wgt)   wgt_r[a_port][a_wq] <= pwdata[6:0];
      if (a_sched) wfq_r[a_port] <= pwdata[SCHED_WFQ];
      if (a_tagmap) tagmap_r <= pwdata[15:0];
      if (a_qmap) two_queue_priority_map_r <= pwdata[QMAP_LSB +: 2];
      if (a_dscp) dscp_r[32*a_dw +: 32] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Per-port split selection
  // ----------------------------------------------------------------
  logic [1:0] split [0:NPORT-1];
  for (genvar p = 0; p < NPORT; p++) begin : g_split
    assign split[p] = {pctl9_r[p][PC9_SPLIT_HI], pctl0_r[p][PC0_SPLIT_LO]};
  end

  // ----------------------------------------------------------------
  // Ingress classification
  // ----------------------------------------------------------------
  logic       src_ok;
  logic       dst_ok;
  logic [7:0] src_ctl;
  logic [1:0] port_prio;
  logic [1:0] tag_prio;
  logic [1:0] dscp_prio;
  logic [1:0] cls_prio;
  logic [1:0] cls_q;
  logic [4:0] push_slot;
  logic       push;

  assign src_ok    = in_src_port < 3'(NPORT);
  assign dst_ok    = in_dst_port < 3'(NPORT);
  assign src_ctl   = src_ok ? pctl0_r[in_src_port] : PCTL0_RST;
  assign port_prio = src_ctl[PC0_PRIO_LSB +: 2];
  assign tag_prio  = tagmap_r[2*in_tag_prio +: 2];
  assign dscp_prio = dscp_r[2*in_tos[7:2] +: 2];
  // Code point outranks tag, tag outranks port level
  assign cls_prio  = (src_ctl[PC0_DSCP_EN] && in_ip)    ? dscp_prio :
                     (src_ctl[PC0_TAG_EN]  && in_tagged) ? tag_prio  : port_prio;
  assign cls_q     = qs_queue_of(split[dst_ok ? in_dst_port : 3'd0], cls_prio,
                                 two_queue_priority_map_r);
  assign push_slot = qs_slot(dst_ok ? in_dst_port : 3'd0, cls_q);
  // A full target queue stalls the fabric; a bad destination port number is swallowed
  assign in_ready  = !dst_ok || (cnt_r[push_slot] != 3'(DEPTH));
  assign push      = in_valid && in_ready && dst_ok;

  // ----------------------------------------------------------------
  // Egress selection
  // ----------------------------------------------------------------
  logic [4:0] pick_valid;
  logic [1:0] pick [0:NPORT-1];
  logic [4:0] take;
  logic [4:0] pop_slot [0:NPORT-1];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    for (genvar q = 0; q < NQ; q++) begin : g_ne
      assign nonempty[p][q] = cnt_r[p*NQ+q] != 3'd0;
    end
    // Only a port with no frame in flight may pick again
    assign take[p]     = pick_valid[p] && !busy_r[p];
    assign pop_slot[p] = qs_slot(3'(p), pick[p]);

    qs_sched u_sched (
      .pclk       (pclk),
      .presetn    (presetn),
      .nonempty   (nonempty[p]),
      .wfq_mode   (wfq_r[p] && split[p] == SPLIT_FOUR),
      .wgt0       (wgt_r[p][0]),
      .wgt1       (wgt_r[p][1]),
      .wgt2       (wgt_r[p][2]),
      .wgt3       (wgt_r[p][3]),
      .take       (take[p]),
      .pick_valid (pick_valid[p]),
      .pick       (pick[p])
    );

    assign eg_valid[p]                 = busy_r[p];
    assign eg_frame_id[p*IDW +: IDW]   = eg_id_r[p];
    assign eg_queue[2*p +: 2]          = eg_q_r[p];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 5'h00;
      for (int p = 0; p < NPORT; p++) begin
        eg_id_r[p] <= '0;
        eg_q_r[p]  <= 2'd0;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (take[p]) begin
          busy_r[p]  <= 1'b1;
          eg_id_r[p] <= mem_r[pop_slot[p]][rd_ptr_r[pop_slot[p]]];
          eg_q_r[p]  <= pick[p];
        end else if (eg_done[p]) begin
          busy_r[p] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Queue pointers; a push and a pop on one slot may share an edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NPORT*NQ; s++) begin
        wr_ptr_r[s] <= 2'd0;
        rd_ptr_r[s] <= 2'd0;
        cnt_r[s]    <= 3'd0;
      end
    end else begin
      for (int s = 0; s < NPORT*NQ; s++) begin
        logic do_push;
        logic do_pop;
        do_push = push && push_slot == 5'(s);
        do_pop  = take[s/NQ] && pop_slot[s/NQ] == 5'(s);
        if (do_push) wr_ptr_r[s] <= wr_ptr_r[s] + 2'd1;
        if (do_pop)  rd_ptr_r[s] <= rd_ptr_r[s] + 2'd1;
        if (do_push && !do_pop) cnt_r[s] <= cnt_r[s] + 3'd1;
        else if (do_pop && !do_push) cnt_r[s] <= cnt_r[s] - 3'd1;
      end
    end
  end

  // Storage has no reset; contents are only read behind a nonzero count
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[push_slot][wr_ptr_r[push_slot]] <= in_frame_id;
    end
  end

endmodule

// file: sim/qs_egress_queue_scheduler_monitor.sv
/*
  Checker for the scheduler top ports: register readback, address span and egress hand-off.
  Assumes registers change only over APB and split settings stay put while frames flow.
*/
module qs_egress_queue_scheduler_monitor (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  input wire logic [4:0]                eg_valid,
  input wire logic [5*qs_pkg::IDW-1:0]  eg_frame_id,
  input wire logic [9:0]                eg_queue,
  input wire logic [4:0]                eg_done
);
  import qs_pkg::*;

  // ------------------------------------------------------------
  // Register shadows
  // ------------------------------------------------------------
  logic             wr_w;
  logic             rd_w;
  logic [7:0]       c0_r [NPORT];
  logic [NPORT-1:0] c9_r;
  logic [6:0]       w_r [NQ];
  logic [1:0]       qm_r;
  logic [15:0]      tm_r;

  assign wr_w = psel && penable && pwrite;
  assign rd_w = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_r <= '{default: PCTL0_RST};
      c9_r <= '0;
      w_r  <= '{WGT0_RST, WGT1_RST, WGT2_RST, WGT3_RST};
      qm_r <= QMAP_RST;
      tm_r <= TAGMAP_RST;
    end else if (wr_w) begin
      for (int i = 0; i < NPORT; i++) begin
        if (paddr == 12'(i) * PORT_STRIDE + 12'(OFF_PCTL0)) c0_r[i] <= pwdata[7:0];
        if (paddr == 12'(i) * PORT_STRIDE + 12'(OFF_PCTL9)) c9_r[i] <= pwdata[PC9_SPLIT_HI];
      end
      for (int k = 0; k < NQ; k++) begin
        if (paddr == 12'(OFF_WGT0) + 12'(4 * k)) w_r[k] <= pwdata[6:0];
      end
      if (paddr == ADDR_QMAP) qm_r <= pwdata[7:6];
      if (paddr == ADDR_TAGMAP) tm_r <= pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_busy(int i); eg_valid[i] && !eg_done[i]; endsequence
  sequence s_end(int i); eg_valid[i] && eg_done[i]; endsequence
  property p_hold(int i);
    s_busy(i) |=> eg_valid[i] && $stable(eg_frame_id[8*i +: 8]) && $stable(eg_queue[2*i +: 2]);
  endproperty
  property p_end(int i); s_end(i) |=> !eg_valid[i]; endproperty
  // Split 00 and the unused 11 both keep one queue
  property p_one(int i); eg_valid[i] && (c9_r[i] == c0_r[i][0]) |-> eg_queue[2*i +: 2] == 2'h0; endproperty
  property p_two(int i); eg_valid[i] && !c9_r[i] && c0_r[i][0] |-> !eg_queue[2*i+1]; endproperty
  property p_wgt;
    rd_w && paddr inside {12'h008, 12'h00c, 12'h010, 12'h014} |-> prdata == {25'h0, w_r[2'(paddr[4:2] - 3'h2)]};
  endproperty
  property p_qmap; rd_w && paddr == ADDR_QMAP |-> prdata == {24'h0, qm_r, 6'h0}; endproperty
  property p_tmap; rd_w && paddr == ADDR_TAGMAP |-> prdata == {16'h0, tm_r}; endproperty
  property p_ctl;
    rd_w && paddr < PORT_SPAN && paddr[4:0] == OFF_PCTL0 |-> prdata == {24'h0, c0_r[paddr[7:5]]};
  endproperty
  property p_span; psel && penable && paddr inside {[12'h0a0 : 12'h0ff]} |-> pslverr; endproperty

  a_wgt: assert property (p_wgt) else $error("weight readback wrong");
  a_qmap: assert property (p_qmap) else $error("two-queue map readback wrong");
  a_tmap: assert property (p_tmap) else $error("tag map readback wrong");
  a_ctl: assert property (p_ctl) else $error("port control readback wrong");
  a_span: assert property (p_span) else $error("port space beyond five ports accepted");
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    a_hold: assert property (p_hold(g)) else $error("egress frame changed in flight");
    a_end: assert property (p_end(g)) else $error("egress busy after done");
    a_one: assert property (p_one(g)) else $error("unsplit port used a queue above 0");
    a_two: assert property (p_two(g)) else $error("two-queue port used queue above 1");
  end
endmodule

bind qs_egress_queue_scheduler qs_egress_queue_scheduler_monitor i_qs_egress_queue_scheduler_monitor (.*);

// file: sim/qs_mac_model.sv
/*
  Egress MAC model for all five ports: takes each frame and reports it finished.
  Assumes eg_valid is a level per port; hold sets cycles of wait before the done pulse.
*/
module qs_mac_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] eg_valid,
  input  wire logic [7:0] hold,
  output logic      [4:0] eg_done
);
  import qs_pkg::*;

  logic [7:0] cnt_r [NPORT];

  // One pulse per frame, never while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= '{default: 8'h0};
      eg_done <= 5'h0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (!eg_valid[p] || eg_done[p]) begin
          cnt_r[p]   <= 8'h0;
          eg_done[p] <= 1'b0;
        end else begin
          cnt_r[p]   <= cnt_r[p] + 8'h1;
          eg_done[p] <= (cnt_r[p] == hold);
        end
      end
    end
  end
endmodule

// file: sim/qs_egress_queue_scheduler_tb.sv
/*
  Self-checking bench: APB registers, classification and per-port queue service.
  Assumes the MAC model on eg_done and the bound checker; frame ids carry the
  expected queue in bits 5:4.
*/
module qs_egress_queue_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import qs_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        in_valid = 1'b0;
  logic        in_ready;
  logic [2:0]  in_src_port = 3'h0;
  logic [2:0]  in_dst_port = 3'h0;
  logic [7:0]  in_frame_id = 8'h0;
  logic        in_tagged = 1'b0;
  logic [2:0]  in_tag_prio = 3'h0;
  logic        in_ip = 1'b0;
  logic [7:0]  in_tos = 8'h0;
  logic [4:0]  eg_valid;
  logic [39:0] eg_frame_id;
  logic [9:0]  eg_queue;
  logic [4:0]  eg_done;
  logic [7:0]  hold = 8'h1e;
  int          n_mismatch = 0;
  int          total_checks = 0;

  always #20 pclk = ~pclk;

  qs_egress_queue_scheduler i_qs_egress_queue_scheduler (.*);
  qs_mac_model i_qs_mac_model (.pclk(pclk), .presetn(presetn), .eg_valid(eg_valid), .hold(hold), .eg_done(eg_done));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [11:0] pa(input int p, input logic [4:0] o);
    return 12'(p) * PORT_STRIDE + 12'(o);
  endfunction
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] x);
    total_checks++;
    if (seen !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(s, r, x);
  endtask
  // Holds in_valid between frames so no edge sees it assigned twice
  task automatic push(input int s, input int d, input logic [7:0] id, input logic tg, input logic [2:0] tp,
                      input logic ip, input logic [7:0] tos);
    int n;
    in_valid <= 1'b1;
    in_src_port <= 3'(s);
    in_dst_port <= 3'(d);
    in_frame_id <= id;
    in_tagged <= tg;
    in_tag_prio <= tp;
    in_ip <= ip;
    in_tos <= tos;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (in_ready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
  endtask
  task automatic pp(input int s, input int d, input logic [7:0] id);
    push(s, d, id, 1'b0, 3'h0, 1'b0, 8'h0);
  endtask
  task automatic idle();
    in_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic gets(input int p, input int n, input logic [159:0] ids);
    int w;
    for (int k = 0; k < n; k++) begin
      w = 0;
      while (eg_valid[p] !== 1'b1 && w < 500) begin
        @(posedge pclk);
        w++;
      end
      chk("egress id", eg_frame_id[8*p +: 8], ids[8*k +: 8]);
      chk("egress queue", eg_queue[2*p +: 2], ids[8*k+4 +: 2]);
      while (eg_valid[p] !== 1'b0 && w < 500) begin
        @(posedge pclk);
        w++;
      end
      if (w >= 500) n_mismatch++;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    for (int k = 0; k < NQ; k++) rd("weight", 12'(OFF_WGT0) + 12'(4 * k), 32'h1 << k);
    rd("ctl0", pa(4, OFF_PCTL0), 32'h0);
    rd("two-queue map", ADDR_QMAP, 32'h80);
    rd("tag map", ADDR_TAGMAP, 32'hfa50);
    apb(1'b0, 12'h0a0, 32'h0, r, e);
    chk("span error", {31'h0, e}, 32'h1);
    chk("span data", r, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    wr(pa(1, OFF_PCTL0), 32'h08);
    wr(pa(1, OFF_PCTL9), 32'h02);
    wr(pa(2, OFF_PCTL0), 32'h11);
    wr(pa(3, OFF_PCTL0), 32'h18);
    wr(pa(3, OFF_PCTL9), 32'h02);
    wr(pa(3, OFF_SCHED), 32'h01);
    wr(pa(4, OFF_PCTL0), 32'h60);
    wr(ADDR_DSCP0, 32'h200);
    wr(ADDR_DSCP3, 32'hc0000000);
    rd("ctl0", pa(3, OFF_PCTL0), 32'h18);
    rd("ctl0", pa(2, OFF_PCTL0), 32'h11);
    rd("sched", pa(3, OFF_SCHED), 32'h1);
    $display("test config done");
  endtask
  task automatic t_single();
    pp(3, 0, 8'h00);
    pp(0, 0, 8'h01);
    pp(3, 0, 8'h02);
    pp(2, 0, 8'h03);
    pp(1, 0, 8'h04);
    idle();
    gets(0, 5, 160'h0403020100);
    $display("test single done");
  endtask
  task automatic t_four();
    pp(0, 1, 8'h00);
    pp(0, 1, 8'h01);
    pp(1, 1, 8'h12);
    pp(2, 1, 8'h23);
    pp(3, 1, 8'h34);
    idle();
    gets(1, 5, 160'h0112233400);
    $display("test four done");
  endtask
  task automatic t_two();
    pp(0, 2, 8'h00);
    pp(0, 2, 8'h01);
    pp(1, 2, 8'h02);
    pp(3, 2, 8'h13);
    pp(2, 2, 8'h14);
    idle();
    gets(2, 5, 160'h0201141300);
    wr(ADDR_QMAP, 32'hc0);
    rd("two-queue map", ADDR_QMAP, 32'hc0);
    pp(0, 2, 8'h05);
    pp(2, 2, 8'h06);
    pp(3, 2, 8'h17);
    idle();
    gets(2, 3, 160'h061705);
    $display("test two done");
  endtask
  task automatic t_class();
    push(4, 1, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00);
    push(4, 1, 8'h01, 1'b1, 3'h1, 1'b0, 8'h00);
    push(4, 1, 8'h22, 1'b1, 3'h5, 1'b0, 8'h00);
    push(4, 1, 8'h33, 1'b1, 3'h7, 1'b0, 8'h00);
    push(4, 1, 8'h34, 1'b1, 3'h0, 1'b1, 8'hfc);
    push(4, 1, 8'h25, 1'b0, 3'h0, 1'b1, 8'h10);
    push(4, 1, 8'h06, 1'b0, 3'h0, 1'b1, 8'h04);
    idle();
    gets(1, 7, 160'h06012522343300);
    $display("test classify done");
  endtask
  task automatic t_wfq();
    pp(3, 3, 8'h30);
    for (int q = 0; q < NQ; q++) begin
      for (int k = 0; k < 4; k++) pp(q, 3, 8'(16 * q + k + (q == 3 ? 1 : 0)));
    end
    idle();
    gets(3, 17, 160'h0302011312001110232221203433323130);
    $display("test weighted done");
  endtask
  // Prompt MAC: frames leave as soon as they land
  task automatic t_prompt();
    hold <= 8'h0;
    fork
      begin
        pp(3, 0, 8'h05);
        pp(1, 0, 8'h06);
        pp(2, 0, 8'h07);
        idle();
      end
      gets(0, 3, 160'h070605);
    join
    $display("test prompt done");
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_cfg();
    t_single();
    t_four();
    t_two();
    t_class();
    t_wfq();
    t_prompt();
    close_out();
  end

  // Whole run needs under two thousand cycles
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule
